// ==== pcs_pkg.sv ====
package pcs_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam logic [11:0] IDX_CAL = 12'h018;
    localparam logic [11:0] IDX_SYNC = 12'h019;
    localparam logic [11:0] IDX_STAT = 12'h01A;
    localparam logic [11:0] IDX_UPD = 12'h232;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CAL_TRIG_BIT = 0;
    localparam int CAL_DIV_LSB = 1;
    localparam int SYNC_MODE_LSB = 6;
    localparam int UPD_BIT = 0;
    localparam int STAT_TRIG_BIT = 2;
    localparam int STAT_SYNC_LSB = 3;
    localparam int STAT_BUSY_BIT = 5;
    localparam logic [1:0] CAL_DIV_RST = 2'h3;
    localparam logic CAL_TRIG_RST = 1'h0;
    localparam logic [1:0] SYNC_MODE_RST = 2'h0;

    // ----------------------------------------
    // Modes, ratios and counts
    // ----------------------------------------
    typedef enum logic [1:0] {
        PCS_SYNC_IGNORE = 2'b00,
        PCS_SYNC_ASYNC = 2'b01,
        PCS_SYNC_SYNC = 2'b10,
        PCS_SYNC_IGNORE_ALT = 2'b11
    } pcs_sync_e;

    typedef enum logic {
        PCS_CAL_IDLE = 1'b0,
        PCS_CAL_RUN = 1'b1
    } pcs_cal_e;

    localparam logic [4:0] RATIO_2 = 5'h02;
    localparam logic [4:0] RATIO_4 = 5'h04;
    localparam logic [4:0] RATIO_8 = 5'h08;
    localparam logic [4:0] RATIO_16 = 5'h10;
    localparam logic [7:0] CAL_TICKS_DEF = 8'h40;
    localparam logic [7:0] R_LEN_DEF = 8'h0A;
    localparam logic [7:0] A_LEN_DEF = 8'h04;
    localparam logic [7:0] B_LEN_DEF = 8'h08;

    function automatic logic [ADDR_W-1:0] pcs_byte_addr(input logic [11:0] idx);
        return {idx, 2'b00};
    endfunction : pcs_byte_addr

    function automatic logic [4:0] pcs_cal_ratio(input logic [1:0] code);
        unique case (code)
            2'b00: return RATIO_2;
            2'b01: return RATIO_4;
            2'b10: return RATIO_8;
            2'b11: return RATIO_16;
        endcase
    endfunction : pcs_cal_ratio

endpackage : pcs_pkg

// ==== pcs_ctrl_if.sv ====
`timescale 1ns/1ps
interface pcs_ctrl_if;
    logic en;
    logic [1:0] cal_div;
    logic cal_trig;
    logic [1:0] sync_mode;
    logic sync_pin;
    logic cal_start;
    logic cal_busy;
    logic cal_tick;
    logic ref_tc;
    logic fb_tc;

    modport top (output en, cal_div, cal_trig, sync_mode, sync_pin,
                 input cal_start, cal_busy, cal_tick, ref_tc, fb_tc);
    modport cal (input en, cal_div, cal_trig, output cal_start, cal_busy, cal_tick);
    modport cnt (input en, sync_mode, sync_pin, output ref_tc, fb_tc);
endinterface : pcs_ctrl_if

// ==== pcs_cal.sv ====
`timescale 1ns/1ps
module pcs_cal #(
    parameter logic [7:0] CAL_TICKS = pcs_pkg::CAL_TICKS_DEF
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    pcs_ctrl_if.cal ctl
);
    import pcs_pkg::*;

    typedef struct packed {
        pcs_cal_e state;
        logic prev;
        logic [4:0] div_cnt;
        logic [7:0] ticks;
        logic start;
        logic tick;
    } pcs_cal_s;

    pcs_cal_s q;
    pcs_cal_s next_q;
    logic [4:0] ratio;

    assign ratio = pcs_cal_ratio(ctl.cal_div);

    always_comb begin
        next_q = q;
        if (ctl.en) begin
            next_q.start = 1'b0;
            next_q.tick = 1'b0;
            next_q.prev = ctl.cal_trig;
            unique case (q.state)
                PCS_CAL_IDLE: begin
                    // Only a rising edge starts a run; a steady one does nothing.
                    if (ctl.cal_trig && !q.prev) begin
                        next_q.state = PCS_CAL_RUN;
                        next_q.start = 1'b1;
                        next_q.div_cnt = 5'h00;
                        next_q.ticks = 8'h00;
                    end
                end
                PCS_CAL_RUN: begin
                    if (q.div_cnt == ratio - 5'h01) begin
                        next_q.div_cnt = 5'h00;
                        next_q.tick = 1'b1;
                        if (q.ticks == CAL_TICKS - 8'h01) begin
                            next_q.state = PCS_CAL_IDLE;
                        end else begin
                            next_q.ticks = q.ticks + 8'h01;
                        end
                    end else begin
                        next_q.div_cnt = q.div_cnt + 5'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign ctl.cal_start = q.start;
    assign ctl.cal_busy = (q.state == PCS_CAL_RUN);
    assign ctl.cal_tick = q.tick;

    sequence s_rise;
        ctl.en && ctl.cal_trig && !q.prev && q.state == PCS_CAL_IDLE;
    endsequence

    AST_CAL_EDGE: assert property (@(posedge clock) disable iff (rst) s_rise |=> q.start && ctl.cal_busy)
        else $error("Rising trigger did not start calibration.");
    AST_CAL_STEADY: assert property (@(posedge clock) disable iff (rst)
        $rose(q.start) |-> $past(ctl.cal_trig) && !$past(q.prev))
        else $error("Calibration started without a rising trigger.");

endmodule : pcs_cal

// ==== pcs_cnt.sv ====
`timescale 1ns/1ps
module pcs_cnt #(
    parameter logic [7:0] R_LEN = pcs_pkg::R_LEN_DEF,
    parameter logic [7:0] A_LEN = pcs_pkg::A_LEN_DEF,
    parameter logic [7:0] B_LEN = pcs_pkg::B_LEN_DEF
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    pcs_ctrl_if.cnt ctl
);
    import pcs_pkg::*;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] a;
        logic [7:0] b;
        logic ref_tc;
        logic fb_tc;
    } pcs_cnt_s;

    pcs_cnt_s q;
    pcs_cnt_s next_q;
    logic aclr;
    logic sclr;

    // The asynchronous clear acts even while the clock enable is low.
    assign aclr = (ctl.sync_mode == PCS_SYNC_ASYNC) && ctl.sync_pin;
    assign sclr = (ctl.sync_mode == PCS_SYNC_SYNC) && ctl.sync_pin;

    always_comb begin
        next_q = q;
        if (ctl.en) begin
            next_q.ref_tc = (q.r == R_LEN - 8'h01);
            next_q.r = next_q.ref_tc ? 8'h00 : q.r + 8'h01;
            next_q.fb_tc = 1'b0;
            if (q.a == A_LEN - 8'h01) begin
                next_q.a = 8'h00;
                next_q.fb_tc = (q.b == B_LEN - 8'h01);
                next_q.b = next_q.fb_tc ? 8'h00 : q.b + 8'h01;
            end else begin
                next_q.a = q.a + 8'h01;
            end
            if (sclr) begin
                next_q = '0;
            end
        end
    end

    always_ff @(posedge clock or posedge aclr) begin
        if (aclr) begin
            q <= '0;
        end else if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign ctl.ref_tc = q.ref_tc;
    assign ctl.fb_tc = q.fb_tc;

    AST_SYNC_CLEAR: assert property (@(posedge clock) disable iff (rst)
        ctl.en && sclr |=> q.r == 8'h00 && q.a == 8'h00 && q.b == 8'h00)
        else $error("Synchronous clear did not reset the counters.");
    AST_ASYNC_CLEAR: assert property (@(posedge clock) disable iff (rst)
        aclr |-> q.r == 8'h00 && q.a == 8'h00 && q.b == 8'h00)
        else $error("Asynchronous clear did not hold the counters.");
    AST_SYNC_IGNORE: assert property (@(posedge clock) disable iff (rst)
        ctl.en && !aclr && !sclr && q.r < R_LEN - 8'h01 ##1 !aclr |-> q.r == $past(q.r) + 8'h01)
        else $error("Counter disturbed while the pin is ignored.");

endmodule : pcs_cnt

// ==== pcs_pll_ctrl.sv ====
`timescale 1ns/1ps
module pcs_pll_ctrl #(
    parameter logic [7:0] CAL_TICKS = pcs_pkg::CAL_TICKS_DEF,
    parameter logic [7:0] R_LEN = pcs_pkg::R_LEN_DEF,
    parameter logic [7:0] A_LEN = pcs_pkg::A_LEN_DEF,
    parameter logic [7:0] B_LEN = pcs_pkg::B_LEN_DEF
) (
    // Clock, reset and enable
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcs_pkg::ADDR_W-1:0] paddr,
    input wire logic [pcs_pkg::DATA_W-1:0] pwdata,
    output logic [pcs_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sync pin
    input wire logic sync_pin,
    // Calibration and counter outputs
    output logic [4:0] calibration_clock_divider,
    output logic cal_start,
    output logic cal_busy,
    output logic cal_tick,
    output logic ref_tick,
    output logic fb_tick
);
    import pcs_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] buf_div;
        logic buf_trig;
        logic [1:0] buf_sync;
        logic [1:0] act_div;
        logic act_trig;
        logic [1:0] act_sync;
        logic ready;
        logic slverr;
        logic [DATA_W-1:0] rdata;
        logic [4:0] ratio;
        logic start;
        logic busy;
        logic tick;
        logic ref_tick;
        logic fb_tick;
    } pcs_top_s;

    pcs_top_s q;
    pcs_top_s next_q;
    logic access;
    logic wr_take;
    logic upd_take;
    logic [DATA_W-1:0] rd_word;

    pcs_ctrl_if ctl ();

    function automatic logic pcs_addr_hit(input logic [ADDR_W-1:0] a);
        return a == pcs_byte_addr(IDX_CAL) || a == pcs_byte_addr(IDX_SYNC) ||
               a == pcs_byte_addr(IDX_STAT) || a == pcs_byte_addr(IDX_UPD);
    endfunction : pcs_addr_hit

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // One wait state keeps read data and the error answer in flip-flops.
    assign access = psel && penable && !q.ready;
    assign wr_take = psel && penable && q.ready && pwrite;
    assign upd_take = wr_take && paddr == pcs_byte_addr(IDX_UPD) && pwdata[UPD_BIT];

    always_comb begin
        rd_word = '0;
        if (paddr == pcs_byte_addr(IDX_CAL)) begin
            rd_word[CAL_TRIG_BIT] = q.buf_trig;
            rd_word[CAL_DIV_LSB +: 2] = q.buf_div;
        end else if (paddr == pcs_byte_addr(IDX_SYNC)) begin
            rd_word[SYNC_MODE_LSB +: 2] = q.buf_sync;
        end else if (paddr == pcs_byte_addr(IDX_STAT)) begin
            rd_word[1:0] = q.act_div;
            rd_word[STAT_TRIG_BIT] = q.act_trig;
            rd_word[STAT_SYNC_LSB +: 2] = q.act_sync;
            rd_word[STAT_BUSY_BIT] = q.busy;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_comb begin
        next_q = q;
        if (clk_en) begin
            next_q.ready = access;
            if (access) begin
                next_q.rdata = pwrite ? '0 : rd_word;
                next_q.slverr = !pcs_addr_hit(paddr);
            end
            if (wr_take && paddr == pcs_byte_addr(IDX_CAL)) begin
                next_q.buf_trig = pwdata[CAL_TRIG_BIT];
                next_q.buf_div = pwdata[CAL_DIV_LSB +: 2];
            end
            if (wr_take && paddr == pcs_byte_addr(IDX_SYNC)) begin
                next_q.buf_sync = pwdata[SYNC_MODE_LSB +: 2];
            end
            // The update bit is a strobe; it is never stored and reads zero.
            if (upd_take) begin
                next_q.act_div = q.buf_div;
                next_q.act_trig = q.buf_trig;
                next_q.act_sync = q.buf_sync;
            end
            next_q.ratio = pcs_cal_ratio(q.act_div);
            next_q.start = ctl.cal_start;
            next_q.busy = ctl.cal_busy;
            next_q.tick = ctl.cal_tick;
            next_q.ref_tick = ctl.ref_tc;
            next_q.fb_tick = ctl.fb_tc;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
            q.buf_div <= CAL_DIV_RST;
            q.buf_trig <= CAL_TRIG_RST;
            q.buf_sync <= SYNC_MODE_RST;
            q.act_div <= CAL_DIV_RST;
            q.act_trig <= CAL_TRIG_RST;
            q.act_sync <= SYNC_MODE_RST;
            q.ratio <= RATIO_16;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------
    // Sub-blocks
    // ----------------------------------------
    // Only the active copy reaches the sub-blocks.
    assign ctl.en = clk_en;
    assign ctl.cal_div = q.act_div;
    assign ctl.cal_trig = q.act_trig;
    assign ctl.sync_mode = q.act_sync;
    assign ctl.sync_pin = sync_pin;

    pcs_cal #(
        .CAL_TICKS(CAL_TICKS)
    ) u_cal (
        .clock(clock),
        .rst(rst),
        .ctl(ctl)
    );

    pcs_cnt #(
        .R_LEN(R_LEN),
        .A_LEN(A_LEN),
        .B_LEN(B_LEN)
    ) u_cnt (
        .clock(clock),
        .rst(rst),
        .ctl(ctl)
    );

    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.slverr;
    assign calibration_clock_divider = q.ratio;
    assign cal_start = q.start;
    assign cal_busy = q.busy;
    assign cal_tick = q.tick;
    assign ref_tick = q.ref_tick;
    assign fb_tick = q.fb_tick;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_update;
        clk_en && upd_take;
    endsequence

    sequence s_quiet;
        !(clk_en && upd_take);
    endsequence

    sequence s_take;
        clk_en && access;
    endsequence

    AST_UPD_COPY: assert property (@(posedge clock) disable iff (rst)
        s_update |=> q.act_div == $past(q.buf_div) && q.act_sync == $past(q.buf_sync) &&
                     q.act_trig == $past(q.buf_trig))
        else $error("Update did not copy the buffer.");
    AST_UPD_HOLD: assert property (@(posedge clock) disable iff (rst)
        s_quiet |=> $stable(q.act_div) && $stable(q.act_sync) && $stable(q.act_trig))
        else $error("Active set changed without an update.");
    AST_DIV_8: assert property (@(posedge clock) disable iff (rst)
        clk_en && q.act_div == 2'b10 |=> calibration_clock_divider == 5'h08)
        else $error("Code 10 did not give ratio 8.");
    AST_DIV_16: assert property (@(posedge clock) disable iff (rst)
        clk_en && q.act_div == 2'b11 |=> calibration_clock_divider == 5'h10)
        else $error("Code 11 did not give ratio 16.");
    AST_DIV_2_4: assert property (@(posedge clock) disable iff (rst)
        clk_en && !q.act_div[1] |=> calibration_clock_divider == ($past(q.act_div[0]) ? 5'h04 : 5'h02))
        else $error("Low codes gave a wrong ratio.");
    AST_RST_DEFAULT: assert property (@(posedge clock) $fell(rst) |-> q.act_div == 2'b11 &&
        q.act_sync == 2'b00 && calibration_clock_divider == 5'h10)
        else $error("Wrong defaults after reset.");
    AST_TRIG_LAUNCH: assert property (@(posedge clock) disable iff (rst)
        clk_en && !cal_busy && !u_cal.q.prev && q.act_trig ##1 clk_en |=> cal_start)
        else $error("Active trigger edge did not reach the start output.");
    AST_APB_WAIT: assert property (@(posedge clock) disable iff (rst)
        s_take ##1 clk_en |-> pready ##1 !pready)
        else $error("Access phase not answered after one wait state.");
    AST_RST_QUIET: assert property (@(posedge clock)
        $fell(rst) |-> !pready && !cal_busy && !cal_start && prdata == '0)
        else $error("Outputs not quiet after reset.");

    // ----------------------------------------
    // Bus answer checks
    // ----------------------------------------
    // The read data and error flops hold still outside an access, so a slow master still reads them.
    AST_APB_MISS: assert property (@(posedge clock) disable iff (rst)
        clk_en && access && !pcs_addr_hit(paddr) |=> pready && pslverr)
        else $error("Unmapped access did not answer with an error.");
    AST_APB_HIT: assert property (@(posedge clock) disable iff (rst)
        clk_en && access && pcs_addr_hit(paddr) |=> pready && !pslverr)
        else $error("Mapped access answered with an error.");
    AST_RD_MISS: assert property (@(posedge clock) disable iff (rst)
        clk_en && access && !pwrite && !pcs_addr_hit(paddr) |=> prdata == '0)
        else $error("Unmapped read returned data.");
    AST_WR_ZERO: assert property (@(posedge clock) disable iff (rst)
        clk_en && access && pwrite |=> prdata == '0)
        else $error("Write answer carried read data.");
    AST_RD_CAL: assert property (@(posedge clock) disable iff (rst)
        clk_en && access && !pwrite && paddr == pcs_byte_addr(IDX_CAL) |=>
        prdata[CAL_DIV_LSB +: 2] == $past(q.buf_div) && prdata[CAL_TRIG_BIT] == $past(q.buf_trig))
        else $error("Calibration control read did not return the buffer.");
    AST_RD_SYNC: assert property (@(posedge clock) disable iff (rst)
        clk_en && access && !pwrite && paddr == pcs_byte_addr(IDX_SYNC) |=> prdata[SYNC_MODE_LSB +: 2] == $past(q.buf_sync))
        else $error("Sync control read did not return the buffer.");
    AST_RD_STAT: assert property (@(posedge clock) disable iff (rst)
        clk_en && access && !pwrite && paddr == pcs_byte_addr(IDX_STAT) |=>
        prdata[1:0] == $past(q.act_div) && prdata[STAT_BUSY_BIT] == $past(cal_busy))
        else $error("Status read did not return the active set.");
    AST_RD_UPD: assert property (@(posedge clock) disable iff (rst)
        clk_en && access && !pwrite && paddr == pcs_byte_addr(IDX_UPD) |=> prdata == '0)
        else $error("Update register did not read zero.");
    AST_RDATA_HOLD: assert property (@(posedge clock) disable iff (rst)
        !(clk_en && access) |=> $stable(prdata))
        else $error("Read data changed outside an access.");
    AST_READY_IDLE: assert property (@(posedge clock) disable iff (rst)
        clk_en && !psel |=> !pready)
        else $error("Ready raised without a selected access.");

    // ----------------------------------------
    // Buffer checks
    // ----------------------------------------
    // Only a completed write may touch the buffer; a refused one leaves it as it was.
    AST_BUF_CAL: assert property (@(posedge clock) disable iff (rst)
        clk_en && wr_take && paddr == pcs_byte_addr(IDX_CAL) |=>
        q.buf_div == $past(pwdata[CAL_DIV_LSB +: 2]) && q.buf_trig == $past(pwdata[CAL_TRIG_BIT]))
        else $error("Calibration control write missed the buffer.");
    AST_BUF_SYNC: assert property (@(posedge clock) disable iff (rst)
        clk_en && wr_take && paddr == pcs_byte_addr(IDX_SYNC) |=> q.buf_sync == $past(pwdata[SYNC_MODE_LSB +: 2]))
        else $error("Sync control write missed the buffer.");
    AST_BUF_OTHER: assert property (@(posedge clock) disable iff (rst)
        clk_en && wr_take && paddr != pcs_byte_addr(IDX_CAL) && paddr != pcs_byte_addr(IDX_SYNC) |=>
        $stable(q.buf_div) && $stable(q.buf_trig) && $stable(q.buf_sync))
        else $error("Write to another register changed the buffer.");
    AST_BUF_HOLD: assert property (@(posedge clock) disable iff (rst)
        !(clk_en && wr_take) |=> $stable(q.buf_div) && $stable(q.buf_trig) && $stable(q.buf_sync))
        else $error("Buffer changed without a write.");

    // ----------------------------------------
    // Output checks
    // ----------------------------------------
    // Every calibration and counter output lags its sub-block by one flop, so the checks look one cycle back.
    AST_FREEZE: assert property (@(posedge clock) disable iff (rst)
        !clk_en |=> $stable(pready) && $stable(prdata) && $stable(cal_busy) &&
        $stable(calibration_clock_divider) && $stable(ref_tick) && $stable(fb_tick))
        else $error("Outputs moved while the clock enable was low.");
    AST_START_ONE: assert property (@(posedge clock) disable iff (rst)
        clk_en && $past(clk_en) && cal_start |=> !cal_start)
        else $error("Start pulse lasted more than one cycle.");
    AST_START_BUSY: assert property (@(posedge clock) disable iff (rst)
        cal_start |-> cal_busy)
        else $error("Start pulse without busy.");
    AST_START_IDLE: assert property (@(posedge clock) disable iff (rst)
        $past(clk_en) && cal_start |-> !$past(cal_busy))
        else $error("Calibration restarted during a run.");
    AST_TICK_IDLE: assert property (@(posedge clock) disable iff (rst)
        $past(clk_en) && !cal_busy && !$past(cal_busy) |-> !cal_tick)
        else $error("Calibration tick while idle.");

endmodule : pcs_pll_ctrl

// ==== pcs_pll_ctrl_tb.sv ====
`timescale 1ns/1ps
module pcs_pll_ctrl_tb;
    import pcs_pkg::*;

    // ----------------------------------------
    // Clock, reset and stimulus
    // ----------------------------------------
    localparam logic [7:0] TB_CAL_TICKS = 8'h03;
    localparam int CEILING = 6000;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic sync_pin = 1'b0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] calibration_clock_divider;
    logic cal_start;
    logic cal_busy;
    logic cal_tick;
    logic ref_tick;
    logic fb_tick;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    int n_start = 0;
    int last_tick = 0;
    int tick_gap = 0;
    int n_ref = 0;
    int n_fb = 0;
    logic cnt_on = 1'b0;
    logic [DATA_W-1:0] rd;
    logic err;

    always #10 clock = ~clock;

    pcs_pll_ctrl #(.CAL_TICKS(TB_CAL_TICKS), .R_LEN(8'h04), .A_LEN(8'h02), .B_LEN(8'h02)) dut (
        .clock(clock), .rst(rst), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_pin(sync_pin),
        .calibration_clock_divider(calibration_clock_divider), .cal_start(cal_start),
        .cal_busy(cal_busy), .cal_tick(cal_tick), .ref_tick(ref_tick), .fb_tick(fb_tick));

    // ----------------------------------------
    // Event counters and timeout
    // ----------------------------------------
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cal_start === 1'b1) begin
            n_start <= n_start + 1;
        end
        if (cal_tick === 1'b1) begin
            tick_gap <= cyc - last_tick;
            last_tick <= cyc;
        end
        if (cnt_on === 1'b1 && ref_tick === 1'b1) begin
            n_ref <= n_ref + 1;
        end
        if (cnt_on === 1'b1 && fb_tick === 1'b1) begin
            n_fb <= n_fb + 1;
        end
        if (cyc == CEILING) begin
            errors = errors + 1;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    // The request stands until the rising edge at which pready is seen high; one idle edge
    // follows so that back-to-back calls never assign psel twice in one time step.
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task automatic update();
        apb(1'b1, IDX_UPD, 32'h0000_0001);
    endtask : update

    task automatic cal_launch(input logic [1:0] code, input int gap);
        int s;
        int n;
        apb(1'b1, IDX_CAL, {29'h0, code, 1'b0});
        update();
        s = n_start;
        apb(1'b1, IDX_CAL, {29'h0, code, 1'b1});
        update();
        n = 0;
        while (n_start == s && n < 10) begin
            @(posedge clock);
            n = n + 1;
        end
        apb(1'b0, IDX_STAT, '0);
        check("stat_busy", rd, {26'h0, 1'b1, 2'b00, 1'b1, code});
        n = 0;
        while (cal_busy !== 1'b0 && n < 200) begin
            @(posedge clock);
            n = n + 1;
        end
        check("starts", n_start - s, 1);
        check("tick_gap", tick_gap, gap);
        s = n_start;
        update();
        repeat (10) @(posedge clock);
        check("steady_no_start", n_start - s, 0);
    endtask : cal_launch

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    logic [4:0] ratios [4] = '{RATIO_2, RATIO_4, RATIO_8, RATIO_16};

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check("div_reset", calibration_clock_divider, 16);
        apb(1'b0, IDX_CAL, '0);
        check("cal_reset", rd, 32'h0000_0006);
        apb(1'b0, IDX_SYNC, '0);
        check("sync_reset", rd, 32'h0000_0000);
        apb(1'b0, IDX_STAT, '0);
        check("stat_reset", rd, 32'h0000_0003);
        apb(1'b0, 12'h3FF, '0);
        check("unmapped_err", err, 1);
        check("unmapped_data", rd, 0);
        apb(1'b1, IDX_STAT, 32'h0000_00FF);
        check("stat_wr_err", err, 0);
        // Buffered writes must not reach the outputs before an update.
        apb(1'b1, IDX_CAL, 32'h0000_0000);
        repeat (3) @(posedge clock);
        check("div_buffered", calibration_clock_divider, 16);
        apb(1'b0, IDX_CAL, '0);
        check("cal_readback", rd, 0);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, IDX_CAL, {29'h0, c[1:0], 1'b0});
            update();
            repeat (2) @(posedge clock);
            check("div_ratio", calibration_clock_divider, ratios[c]);
            apb(1'b0, IDX_STAT, '0);
            check("stat_div", rd, {30'h0, c[1:0]});
        end
        apb(1'b0, IDX_UPD, '0);
        check("upd_read", rd, 0);
        cal_launch(2'b11, 16);
        cal_launch(2'b00, 2);
        // Counters keep running in the ignore modes and stay cleared otherwise.
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, IDX_SYNC, {24'h0, m[1:0], 6'h0});
            update();
            apb(1'b0, IDX_SYNC, '0);
            check("sync_readback", rd, {24'h0, m[1:0], 6'h0});
            n_ref <= 0;
            n_fb <= 0;
            sync_pin <= 1'b1;
            repeat (4) @(posedge clock);
            cnt_on <= 1'b1;
            repeat (40) @(posedge clock);
            cnt_on <= 1'b0;
            sync_pin <= 1'b0;
            repeat (2) @(posedge clock);
            check("ref_ticks", n_ref, (m == 1 || m == 2) ? 0 : 10);
            check("fb_ticks", n_fb, (m == 1 || m == 2) ? 0 : 10);
        end
        // A low clock enable must hold the bus answer back until it returns.
        clk_en <= 1'b0;
        fork
            apb(1'b0, IDX_SYNC, '0);
            begin
                repeat (6) @(posedge clock);
                check("frozen_ready", pready, 0);
                clk_en <= 1'b1;
            end
        join
        check("frozen_read", rd, 32'h0000_00C0);
        end_of_test();
    end

endmodule : pcs_pll_ctrl_tb
